// ===== verilog/flash_crc_host.sv
// Host controller that issues the flash CRC check command and polls.
// Assumes a flash on asynchronous pins; data pins pass a synchroniser.
`timescale 1ns/1ps
`include "flash_crc_defines.svh"
// Operation
// RULE1: Two unlock writes then extended code.
// RULE2: Sub-opcode, count, option selects range or array.
// RULE3: Range count is 000Ah word, 15h byte.
// RULE4: Array count 0004h/09h, no address words.
// RULE5: Expected CRC as four words, offsets one-four.
// RULE6: Byte mode: low byte even, high next.
// RULE7: Start address words at offsets five, six.
// RULE8: Stop address after reserved; reserved as zero.
// RULE9: Device skips CRC when stop not above start.
// RULE10: Range addresses are byte addresses always.
// RULE11: Confirm 29h starts check; host polls ready.
// RULE12: Mismatch drives error status bit five high.
// RULE13: Device uses the standard 64-bit polynomial.
// RULE14: Device feeds data LSB first, zero init.
// RULE15: Device reports pass or fail by polling.
// RULE16: First CRC word is least significant.
module flash_crc_host
	import flash_crc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cmdStart,
	input wire logic rangeMode,
	input wire logic byteMode,
	input wire logic [63:0] expectedCrc,
	input wire logic [31:0] startAddr,
	input wire logic [31:0] stopAddr,
	input wire logic [15:0] dqIn,
	output logic [30:0] flashAddr,
	output logic [15:0] dqOut,
	output logic dqOe,
	output logic ceN,
	output logic weN,
	output logic oeN,
	output logic busy,
	output logic doneP,
	output logic checkErrorFlag
);
	seq_state_e state_q;
	logic [4:0] step_q;
	logic half_q;
	logic range_q;
	logic byte_q;
	logic [63:0] crc_q;
	logic [31:0] start_q;
	logic [31:0] stop_q;
	logic [15:0] dqMeta_q;
	logic [15:0] dqSync_q;
	logic cycStart_q;
	logic cycWrite_q;
	logic [30:0] cycAddr_q;
	logic [15:0] cycData_q;
	logic cycDone;
	logic [15:0] cycRd;
	logic [15:0] wordVal;
	logic [30:0] wordAddr;
	logic [4:0] lastStep;

	// -------------------------------------------------
	// Data pin synchroniser.
	// -------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dqMeta_q <= 16'h0;
			dqSync_q <= 16'h0;
		end else begin
			dqMeta_q <= dqIn;
			dqSync_q <= dqMeta_q;
		end
	end

	// -------------------------------------------------
	// Command word table.
	// -------------------------------------------------
	// Step 0..4 are the fixed prefix; 5.. are parameter words by offset.
	always_comb begin
		wordVal = `RESERVED_DATA;
		wordAddr = 31'h0;
		lastStep = range_q ? 5'(5 + `RANGE_OFS_LAST + 1)
			: 5'(5 + `CRC_OFS_LAST + 1);
		case (step_q)
			5'd0: begin
				wordVal = `UNLOCK1_DATA; // RULE1
				wordAddr = byte_q ? `UNLOCK1_BADDR : `UNLOCK1_WADDR;
			end
			5'd1: begin
				wordVal = `UNLOCK2_DATA; // RULE1
				wordAddr = byte_q ? `UNLOCK2_BADDR : `UNLOCK2_WADDR;
			end
			5'd2: wordVal = `EXTFN_DATA; // RULE1
			5'd3: wordVal = `CRC_SUBOP_DATA; // RULE2
			5'd4: begin
				if (range_q) begin
					wordVal = byte_q ? `CNT_RANGE_BYTE
						: `CNT_RANGE_WORD; // RULE3
				end else begin
					wordVal = byte_q ? `CNT_ARRAY_BYTE
						: `CNT_ARRAY_WORD; // RULE4
				end
			end
			5'd5: wordVal = range_q ? `OPT_RANGE : `OPT_ARRAY; // RULE2
			5'd6: wordVal = crc_q[15:0]; // RULE5 RULE16
			5'd7: wordVal = crc_q[31:16]; // RULE5
			5'd8: wordVal = crc_q[47:32]; // RULE5
			5'd9: wordVal = crc_q[63:48]; // RULE5
			5'd10: wordVal = start_q[15:0]; // RULE7 RULE10
			5'd11: wordVal = start_q[31:16]; // RULE7
			5'd13: wordVal = stop_q[15:0]; // RULE8
			5'd14: wordVal = stop_q[31:16]; // RULE8
			default: wordVal = `RESERVED_DATA; // RULE8
		endcase
		if (step_q == lastStep) begin
			wordVal = `CONFIRM_DATA; // RULE11
		end else if (step_q >= 5'd5 && step_q < lastStep) begin
			wordAddr = 31'(step_q - 5'd5);
		end
	end

	// -------------------------------------------------
	// Sequence control and parameter capture.
	// -------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= SEQ_IDLE;
			step_q <= 5'h0;
			half_q <= 1'b0;
			range_q <= 1'b0;
			byte_q <= 1'b0;
			crc_q <= 64'h0;
			start_q <= 32'h0;
			stop_q <= 32'h0;
			cycStart_q <= 1'b0;
			cycWrite_q <= 1'b0;
			cycAddr_q <= 31'h0;
			cycData_q <= 16'h0;
			busy <= 1'b0;
			doneP <= 1'b0;
			checkErrorFlag <= 1'b0;
		end else begin
			cycStart_q <= 1'b0;
			doneP <= 1'b0;
			case (state_q)
				SEQ_IDLE: begin
					if (cmdStart) begin
						range_q <= rangeMode;
						byte_q <= byteMode;
						crc_q <= expectedCrc;
						start_q <= startAddr;
						stop_q <= stopAddr;
						step_q <= 5'h0;
						half_q <= 1'b0;
						busy <= 1'b1;
						checkErrorFlag <= 1'b0;
						state_q <= SEQ_WRITE;
					end
				end
				SEQ_WRITE: begin
					cycStart_q <= 1'b1;
					cycWrite_q <= 1'b1;
					// Byte mode splits each word from step 5 on except the confirm; prefix steps 0..4 are bytes.
					if (byte_q && step_q >= 5'd5 && step_q != lastStep) begin
						cycAddr_q <= {wordAddr[29:0], half_q}; // RULE6
						cycData_q <= half_q ? {8'h0, wordVal[15:8]}
							: {8'h0, wordVal[7:0]}; // RULE6
					end else begin
						cycAddr_q <= wordAddr;
						cycData_q <= byte_q ? {8'h0, wordVal[7:0]} : wordVal;
					end
					state_q <= SEQ_WAIT;
				end
				SEQ_WAIT: begin
					if (cycDone) begin
						if (!cycWrite_q) begin
							if (cycRd[`READY_BIT]) begin
								checkErrorFlag <= cycRd[`ERR_BIT]; // RULE12 RULE15
								busy <= 1'b0;
								doneP <= 1'b1;
								state_q <= SEQ_IDLE;
							end else begin
								state_q <= SEQ_POLL; // RULE11
							end
						end else if (byte_q && step_q >= 5'd5 && !half_q
							&& step_q != lastStep) begin
							half_q <= 1'b1;
							state_q <= SEQ_WRITE;
						end else if (step_q == lastStep) begin
							state_q <= SEQ_POLL;
						end else begin
							half_q <= 1'b0;
							step_q <= step_q + 5'h1;
							state_q <= SEQ_WRITE;
						end
					end
				end
				SEQ_POLL: begin
					cycStart_q <= 1'b1;
					cycWrite_q <= 1'b0;
					cycAddr_q <= 31'h0;
					state_q <= SEQ_WAIT;
				end
				default: state_q <= SEQ_IDLE;
			endcase
		end
	end

	flash_bus_cycle u_cycle (
		.clk(clk),
		.arst_n(arst_n),
		.start(cycStart_q),
		.isWrite(cycWrite_q),
		.addrIn(cycAddr_q),
		.dataIn(cycData_q),
		.dqSync(dqSync_q),
		.done(cycDone),
		.rdData(cycRd),
		.addr(flashAddr),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.ceN(ceN),
		.weN(weN),
		.oeN(oeN)
	);

	// Confirm write is followed by a poll read, never another write.
	sequence s_confirm;
		cycStart_q && cycWrite_q && cycData_q == `CONFIRM_DATA
			&& step_q == lastStep;
	endsequence
	property p_poll_after_confirm;
		@(posedge clk) disable iff (!arst_n)
		s_confirm |-> ##[1:40] (cycStart_q && !cycWrite_q);
	endproperty
	a_poll_after_confirm: assert property (p_poll_after_confirm) // RULE11
		else $error("no poll after confirm");

	// First command write of a sequence is the first unlock code.
	property p_first_unlock;
		@(posedge clk) disable iff (!arst_n)
		(state_q == SEQ_IDLE && cmdStart) |=> ##1
			(cycData_q[7:0] == 8'hAA);
	endproperty
	a_first_unlock: assert property (p_first_unlock) // RULE1
		else $error("sequence did not open with unlock");

	// Count step carries the count that matches mode.
	property p_count;
		@(posedge clk) disable iff (!arst_n)
		(cycStart_q && cycWrite_q && step_q == 5'd4) |->
			(cycData_q == (range_q ? (byte_q ? `CNT_RANGE_BYTE
			: `CNT_RANGE_WORD) : (byte_q ? `CNT_ARRAY_BYTE
			: `CNT_ARRAY_WORD)));
	endproperty
	a_count: assert property (p_count) // RULE3
		else $error("wrong data count");

	// Word-mode array command never writes past the fourth CRC word.
	property p_array_len;
		@(posedge clk) disable iff (!arst_n)
		(cycStart_q && cycWrite_q && !range_q && !byte_q) |->
			(cycAddr_q <= `CRC_OFS_LAST || cycAddr_q == `UNLOCK1_WADDR
			|| cycAddr_q == `UNLOCK2_WADDR);
	endproperty
	a_array_len: assert property (p_array_len) // RULE4
		else $error("array mode wrote address words");

	// Byte mode: high half goes to odd location after low half.
	property p_byte_pair;
		@(posedge clk) disable iff (!arst_n)
		(cycStart_q && cycWrite_q && byte_q && half_q) |->
			cycAddr_q[0];
	endproperty
	a_byte_pair: assert property (p_byte_pair) // RULE6
		else $error("high byte not at odd location");

	// Error flag changes only when a sequence finishes or starts.
	property p_err_stable;
		@(posedge clk) disable iff (!arst_n)
		(busy && !doneP) |=> (!$changed(checkErrorFlag) || doneP);
	endproperty
	a_err_stable: assert property (p_err_stable) // RULE12
		else $error("error flag moved mid sequence");

	// Done pulse is a single cycle and clears busy.
	property p_done;
		@(posedge clk) disable iff (!arst_n)
		doneP |-> (!busy ##1 !doneP);
	endproperty
	a_done: assert property (p_done) // RULE15
		else $error("done pulse malformed");

	// First CRC word carries the low sixteen bits.
	property p_crc_low;
		@(posedge clk) disable iff (!arst_n)
		(cycStart_q && cycWrite_q && step_q == 5'd6 && !byte_q) |->
			(cycData_q == crc_q[15:0] && cycAddr_q == 31'h1);
	endproperty
	a_crc_low: assert property (p_crc_low) // RULE16
		else $error("first crc word misplaced");
endmodule

// ===== pkg/flash_crc_defines.svh
// Constants for the flash CRC check command sequencer.
// Assumes inclusion by the host controller and its pin cycle engine.
`ifndef FLASH_CRC_DEFINES_SVH
`define FLASH_CRC_DEFINES_SVH
`define UNLOCK1_WADDR 31'h0000555
`define UNLOCK2_WADDR 31'h00002AA
`define UNLOCK1_BADDR 31'h0000AAA
`define UNLOCK2_BADDR 31'h0000555
`define UNLOCK1_DATA 16'h00AA
`define UNLOCK2_DATA 16'h0055
`define EXTFN_DATA 16'h00EB
`define CRC_SUBOP_DATA 16'h0027
`define CNT_RANGE_WORD 16'h000A
`define CNT_RANGE_BYTE 16'h0015
`define CNT_ARRAY_WORD 16'h0004
`define CNT_ARRAY_BYTE 16'h0009
`define OPT_RANGE 16'hFFFE
`define OPT_ARRAY 16'hFFFF
`define RESERVED_DATA 16'h0000
`define CONFIRM_DATA 16'h0029
`define START_LO_WOFS 31'h0000005
`define STOP_LO_WOFS 31'h0000008
`define CRC_OFS_LAST 31'h0000004
`define RANGE_OFS_LAST 31'h000000A
`define ERR_BIT 5
`define READY_BIT 7
`define SETUP_NS 40
`define STROBE_NS 56
`define HOLD_NS 40
`define CLK_NS 8
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== pkg/flash_crc_pkg.sv
// Types for the flash CRC check command sequencer.
// Assumes the defines header is compiled alongside.
package flash_crc_pkg;
	typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD}
		cyc_state_e;
	typedef enum logic [2:0] {SEQ_IDLE, SEQ_WRITE, SEQ_POLL, SEQ_WAIT,
		SEQ_DONE} seq_state_e;
endpackage

// ===== verilog/flash_bus_cycle.sv
// Single asynchronous flash bus cycle engine, write or read.
// Assumes pin timing that fits the setup, strobe and hold counts.
`timescale 1ns/1ps
`include "flash_crc_defines.svh"
module flash_bus_cycle
	import flash_crc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic isWrite,
	input wire logic [30:0] addrIn,
	input wire logic [15:0] dataIn,
	input wire logic [15:0] dqSync,
	output logic done,
	output logic [15:0] rdData,
	output logic [30:0] addr,
	output logic [15:0] dqOut,
	output logic dqOe,
	output logic ceN,
	output logic weN,
	output logic oeN
);
	cyc_state_e state_q;
	logic [3:0] cnt_q;
	logic wr_q;

	// -------------------------------------------------
	// Cycle sequencing: setup, strobe, hold.
	// -------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= CYC_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			done <= 1'b0;
			addr <= 31'h0;
			dqOut <= 16'h0;
			dqOe <= 1'b0;
			ceN <= 1'b1;
			weN <= 1'b1;
			oeN <= 1'b1;
			rdData <= 16'h0;
		end else begin
			done <= 1'b0;
			case (state_q)
				CYC_IDLE: begin
					if (start) begin
						state_q <= CYC_SETUP;
						cnt_q <= 4'(`SETUP_CYC);
						wr_q <= isWrite;
						addr <= addrIn;
						dqOut <= dataIn;
						dqOe <= isWrite;
						ceN <= 1'b0;
					end
				end
				CYC_SETUP: begin
					if (cnt_q <= 4'h1) begin
						state_q <= CYC_STROBE;
						cnt_q <= 4'(`STROBE_CYC);
						weN <= ~wr_q;
						oeN <= wr_q;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				CYC_STROBE: begin
					if (cnt_q <= 4'h1) begin
						state_q <= CYC_HOLD;
						cnt_q <= 4'(`HOLD_CYC);
						weN <= 1'b1;
						oeN <= 1'b1;
						rdData <= dqSync;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				CYC_HOLD: begin
					if (cnt_q <= 4'h1) begin
						state_q <= CYC_IDLE;
						ceN <= 1'b1;
						dqOe <= 1'b0;
						done <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: state_q <= CYC_IDLE;
			endcase
		end
	end

	// Write strobe never overlaps output enable.
	property p_no_overlap;
		@(posedge clk) disable iff (!arst_n) !(!weN && !oeN);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("write and read strobes overlap");
endmodule

// ===== tb/flash_crc_model.sv
// Behavioural flash device that decodes the CRC check command and polls.
// Assumes a host that writes on the weN rise and reads with oeN low.
`timescale 1ns/1ps
`include "flash_crc_defines.svh"
module flash_crc_model
	import flash_crc_pkg::*;
#(
	parameter logic [63:0] ARRAY_CRC = 64'h0123456789ABCDEF,
	parameter int BUSY_READS = 3
) (
	input wire logic arst_n,
	input wire logic byteMode,
	input wire logic [30:0] flashAddr,
	input wire logic [15:0] dqOut,
	input wire logic dqOe,
	input wire logic ceN,
	input wire logic weN,
	input wire logic oeN,
	output logic [15:0] dqIn,
	output logic [7:0] nWrites,
	output logic [7:0] nPolls,
	output logic seqErr,
	output logic [15:0] cnt,
	output logic [15:0] gotOpt,
	output logic [63:0] gotCrc,
	output logic [31:0] gotStart,
	output logic [31:0] gotStop
);
	logic [15:0] pw [0:15];
	logic [15:0] lastRd;
	logic [15:0] stat;
	logic wrKind, fresh, running, fail, rangeSel;

	// --------
	// Parameter decode and poll status.
	// --------
	// The first word is the least significant part of the value.
	assign gotCrc = {pw[4], pw[3], pw[2], pw[1]};
	assign gotStart = {pw[6], pw[5]};
	assign gotStop = {pw[9], pw[8]};
	assign gotOpt = pw[0];
	// Ready on bit seven, check error on bit five once ready.
	assign stat = {8'h00, !running, 1'b0, fail & !running, 5'h00};
	// A released bus shows the inverse of the last value read.
	assign dqIn = (!ceN && !oeN) ? stat : ~lastRd;

	// Remembers whether the bus cycle now ending is a write or a read.
	always @(negedge weN or negedge oeN) wrKind = !weN;

	// Flags a prefix or confirm write with the wrong location or code.
	task automatic chk(input logic [30:0] a, input logic [7:0] d);
		if (flashAddr !== a || dqOut !== {8'h00, d}) seqErr = 1'b1;
	endtask

	// Latches writes on the weN rise and counts polls on the oeN rise.
	always @(posedge weN or posedge oeN or negedge arst_n) begin
		if (!arst_n) begin
			nWrites = 8'h00;
			nPolls = 8'h00;
			seqErr = 1'b0;
			cnt = 16'h0000;
			running = 1'b0;
			fail = 1'b0;
			fresh = 1'b1;
			lastRd = 16'h0000;
			for (int k = 0; k < 16; k++) pw[k] = 16'h0000;
		end else if (!ceN && wrKind) begin
			if (fresh) begin
				nWrites = 8'h00;
				seqErr = 1'b0;
				fresh = 1'b0;
				for (int k = 0; k < 16; k++) pw[k] = 16'h0000;
			end
			if (!dqOe) seqErr = 1'b1;
			case (nWrites)
				8'h00: chk(byteMode ? `UNLOCK1_BADDR : `UNLOCK1_WADDR, 8'hAA);
				8'h01: chk(byteMode ? `UNLOCK2_BADDR : `UNLOCK2_WADDR, 8'h55);
				8'h02: chk(31'h0000000, 8'hEB);
				8'h03: chk(31'h0000000, 8'h27);
				8'h04: cnt = byteMode ? {8'h00, dqOut[7:0]} : dqOut;
				default: begin
					// The count places the confirm write; it starts the check.
					if (nWrites == cnt[7:0] + 8'h06) begin
						chk(31'h0000000, 8'h29);
						rangeSel = pw[0] == `OPT_RANGE;
						if (rangeSel && (pw[7] | pw[10]) != 16'h0000) seqErr = 1'b1;
						// The array value stands in for the computed code.
						fail = !(rangeSel && gotStop <= gotStart)
							&& gotCrc != ARRAY_CRC;
						running = 1'b1;
						nPolls = 8'h00;
					end else if (byteMode && flashAddr[0]) begin
						pw[flashAddr[4:1]][15:8] = dqOut[7:0];
					end else if (byteMode) begin
						pw[flashAddr[4:1]][7:0] = dqOut[7:0];
					end else begin
						pw[flashAddr[3:0]] = dqOut;
					end
				end
			endcase
			nWrites = nWrites + 8'h01;
		end else if (!ceN) begin
			if (dqOe) seqErr = 1'b1;
			lastRd = stat;
			nPolls = nPolls + 8'h01;
			if (running && nPolls >= BUSY_READS) begin
				running = 1'b0;
				fresh = 1'b1;
			end
		end
	end
endmodule

// ===== tb/tb_flash_crc_host.sv
// Self-checking bench for the flash CRC check command host controller.
// Assumes the behavioural flash model answers on the controller's pins.
`timescale 1ns/1ps
module tb_flash_crc_host
	import flash_crc_pkg::*;
;
	localparam int POLLS = 3;
	localparam logic [63:0] GOOD = 64'h0123456789ABCDEF;
	localparam logic [63:0] BAD = 64'h0123456789ABCDEE;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmdStart = 1'b0;
	logic rangeMode = 1'b0;
	logic byteMode = 1'b0;
	logic [63:0] expectedCrc = 64'h0;
	logic [31:0] startAddr = 32'h0;
	logic [31:0] stopAddr = 32'h0;
	logic [15:0] dqIn, dqOut, cnt, gotOpt;
	logic [30:0] flashAddr;
	logic dqOe, ceN, weN, oeN, busy, doneP, checkErrorFlag, seqErr;
	logic [7:0] nWrites, nPolls;
	logic [63:0] gotCrc;
	logic [31:0] gotStart, gotStop;
	int mismatches = 0;
	int testsRun = 0;

	// --------
	// Clock and instances.
	// --------
	// Free-running clock of 8 ns.
	always #4 clk = ~clk;

	flash_crc_host i_dut (.clk(clk), .arst_n(arst_n), .cmdStart(cmdStart),
		.rangeMode(rangeMode), .byteMode(byteMode), .expectedCrc(expectedCrc),
		.startAddr(startAddr), .stopAddr(stopAddr), .dqIn(dqIn),
		.flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN),
		.weN(weN), .oeN(oeN), .busy(busy), .doneP(doneP),
		.checkErrorFlag(checkErrorFlag));

	flash_crc_model #(.ARRAY_CRC(GOOD), .BUSY_READS(POLLS)) i_flash (
		.arst_n(arst_n), .byteMode(byteMode), .flashAddr(flashAddr),
		.dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .weN(weN), .oeN(oeN),
		.dqIn(dqIn), .nWrites(nWrites), .nPolls(nPolls), .seqErr(seqErr),
		.cnt(cnt), .gotOpt(gotOpt), .gotCrc(gotCrc), .gotStart(gotStart),
		.gotStop(gotStop));

	// --------
	// Check and stimulus tasks.
	// --------
	// Prints the counts and the verdict, then ends the run.
	task automatic printVerdict();
		$display("Comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp1(input string what, input logic exp, input logic got);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cmp64(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Requests one command, optionally again while busy, waits for done.
	task automatic runCmd(input logic rng, input logic byt,
		input logic [63:0] crc, input logic [31:0] sa, input logic [31:0] so,
		input logic again);
		int i;
		@(negedge clk);
		rangeMode = rng;
		byteMode = byt;
		expectedCrc = crc;
		startAddr = sa;
		stopAddr = so;
		cmdStart = 1'b1;
		@(negedge clk);
		cmdStart = 1'b0;
		cmp1("busy", 1'b1, busy);
		if (again) begin
			repeat (50) @(negedge clk);
			cmdStart = 1'b1;
			@(negedge clk);
			cmdStart = 1'b0;
		end
		for (i = 0; i < 5000 && doneP !== 1'b1; i++) @(negedge clk);
		if (doneP !== 1'b1) begin
			mismatches++;
			$display("ERROR doneP expected 1 seen timeout");
			printVerdict();
		end
	endtask

	// Checks what every command must deliver to the device.
	task automatic checkBase(input logic [63:0] crc);
		cmp1("sequence error", 1'b0, seqErr);
		cmp64("expected crc", crc, gotCrc);
		cmp64("polls", 64'(POLLS + 1), 64'(nPolls));
	endtask

	// --------
	// Scenario tasks.
	// --------
	task automatic wordArrayPass();
		runCmd(1'b0, 1'b0, GOOD, 32'h0, 32'h0, 1'b1);
		checkBase(GOOD);
		cmp64("count", 64'h4, 64'(cnt));
		cmp64("option", 64'hFFFF, 64'(gotOpt));
		cmp64("writes", 64'd11, 64'(nWrites));
		cmp1("error flag", 1'b0, checkErrorFlag);
		repeat (3) @(negedge clk);
		cmp1("busy", 1'b0, busy);
	endtask

	task automatic wordRangeFail();
		runCmd(1'b1, 1'b0, BAD, 32'h12345678, 32'h12349ABC, 1'b0);
		checkBase(BAD);
		cmp64("count", 64'hA, 64'(cnt));
		cmp64("option", 64'hFFFE, 64'(gotOpt));
		cmp64("start", 64'h12345678, 64'(gotStart));
		cmp64("stop", 64'h12349ABC, 64'(gotStop));
		cmp64("writes", 64'd17, 64'(nWrites));
		cmp1("error flag", 1'b1, checkErrorFlag);
	endtask

	task automatic byteRangePass();
		runCmd(1'b1, 1'b1, GOOD, 32'h0ABCDEF1, 32'h0ABD0002, 1'b0);
		checkBase(GOOD);
		cmp64("count", 64'h15, 64'(cnt));
		cmp64("option", 64'hFFFE, 64'(gotOpt));
		cmp64("start", 64'h0ABCDEF1, 64'(gotStart));
		cmp64("stop", 64'h0ABD0002, 64'(gotStop));
		cmp64("writes", 64'd28, 64'(nWrites));
		cmp1("error flag", 1'b0, checkErrorFlag);
	endtask

	task automatic byteArrayFail();
		runCmd(1'b0, 1'b1, BAD, 32'h0, 32'h0, 1'b0);
		checkBase(BAD);
		cmp64("count", 64'h9, 64'(cnt));
		cmp64("option", 64'hFFFF, 64'(gotOpt));
		cmp64("writes", 64'd16, 64'(nWrites));
		cmp1("error flag", 1'b1, checkErrorFlag);
	endtask

	task automatic rangeNoAction();
		runCmd(1'b1, 1'b0, BAD, 32'h00004000, 32'h00004000, 1'b0);
		checkBase(BAD);
		cmp1("error flag", 1'b0, checkErrorFlag);
	endtask

	// Holds reset for twelve cycles, then runs every scenario.
	initial begin
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		wordArrayPass();
		wordRangeFail();
		byteRangePass();
		byteArrayFail();
		rangeNoAction();
		printVerdict();
	end
endmodule
